// >>> tb/lhp_periph.sv
// peripheral model: drives the request pin and the input data pins
`timescale 1ns/1ns
module lhp_periph (
   // clock
   input  wire logic        i_core_clk,
   // device pins
   output logic             o_req,
   output logic [31:0]      o_din
);
   logic act = 1'b1;
   initial begin
      o_req = 1'b0;
      o_din = 32'h0;
   end
   // ***************************************************
   // request level, active or inactive
   // ***************************************************
   task automatic lvl(input logic a);
      @(posedge i_core_clk);
      o_req <= a ? act : !act;
   endtask
   // ***************************************************
   // strobe: inactive, then active, data swapped between edges
   // ***************************************************
   task automatic strobe(input logic [31:0] w1, input logic [31:0] w2);
      @(posedge i_core_clk);
      o_req <= !act;
      o_din <= w1;
      repeat (5) @(posedge i_core_clk);
      o_req <= act;
      repeat (5) @(posedge i_core_clk);
      o_din <= w2;
      repeat (5) @(posedge i_core_clk);
      o_req <= !act;
      repeat (5) @(posedge i_core_clk);
      // hold time over: the old word must not linger on the pins
      o_din <= ~w2;
      #1;
   endtask
endmodule

// >>> tb/tb_top.sv
// testbench of the handshake port: register tasks and scenarios
`timescale 1ns/1ns
module tb_top;
   import lhp_pkg::*;
   logic              i_core_clk;
   logic              i_rst_n;
   logic [ADDR_W-1:0] i_addr;
   logic [31:0]       i_wdata;
   logic              i_wr;
   logic              i_rd;
   logic [31:0]       o_rdata;
   logic              i_req;
   logic              o_ack;
   logic [31:0]       i_din;
   logic [31:0]       o_dout;
   logic              o_dout_oe;
   int                error_cnt = 0;
   int                num_checks = 0;
   int                n;
   logic              apol = 1'b1;
   logic [31:0]       last;

   lhp_port #(.DATA_W(32)) u_dut (
      .i_core_clk(i_core_clk),
      .i_rst_n   (i_rst_n),
      .i_addr    (i_addr),
      .i_wdata   (i_wdata),
      .i_wr      (i_wr),
      .i_rd      (i_rd),
      .o_rdata   (o_rdata),
      .i_req     (i_req),
      .o_ack     (o_ack),
      .i_din     (i_din),
      .o_dout    (o_dout),
      .o_dout_oe (o_dout_oe)
   );
   lhp_periph u_per (.i_core_clk(i_core_clk), .o_req(i_req), .o_din(i_din));

   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   // ***************************************************
   // shared tasks
   // ***************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_core_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, exp);
   endtask
   // counts cycles until the readiness pin shows v; bounded wait
   task automatic wait_ack(input logic v, output int k);
      k = 0;
      while (o_ack !== (v ? apol : !apol) && k < 3000) begin
         cyc(1);
         k++;
      end
      if (k == 3000) begin
         error_cnt++;
         $display("unexpected at %0t: readiness never changed", $time);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic s_reset();
      chk(o_ack, 1'b0);
      chk(o_dout_oe, 1'b0);
      rd(ADR_CTRL, 32'h0070);
      rd(ADR_STAT, 32'h0);
      rd(4'h2, 32'h0);
   endtask
   task automatic s_level_in();
      wr(ADR_CTRL, 32'h71);
      cyc(30);
      chk(o_ack, 1'b0);
      u_per.lvl(1'b1);
      wait_ack(1'b1, n);
      // protocol is locked once a transfer is under way
      wr(ADR_CTRL, 32'h75);
      rd(ADR_CTRL, 32'h71);
      cyc(20);
      chk(o_ack, 1'b1);
      u_per.strobe(32'hA5A5_0001, 32'h5A5A_0002);
      chk(o_ack, 1'b0);
      cyc(40);
      chk(o_ack, 1'b0);
      last = 32'hA5A5_0001;
   endtask
   task automatic s_delay();
      int dl[2] = '{7, 0};
      foreach (dl[i]) begin
         wr(ADR_CTRL, 32'h71 | (dl[i] << CB_DLY));
         rd(ADR_DIN, last);
         wait_ack(1'b1, n);
         chk(n >= 10 * dl[i] && n <= 10 * dl[i] + 8, 1'b1);
         last = 32'h3C00_0000 + i;
         u_per.strobe(last, ~last);
      end
      rd(ADR_DIN, last);
   endtask
   // latching off: the pending word is taken when readiness returns
   task automatic s_no_latch();
      wr(ADR_CTRL, 32'h0);
      wr(ADR_CTRL, 32'h31);
      u_per.strobe(32'h0F0F_0001, 32'h0F0F_0002);
      chk(o_ack, 1'b1);
      u_per.strobe(32'h0F0F_0003, 32'h0F0F_0004);
      chk(o_ack, 1'b1);
      rd(ADR_DIN, 32'h0F0F_0003);
   endtask
   task automatic s_level_out();
      wr(ADR_CTRL, 32'h0);
      wr(ADR_CTRL, 32'h73);
      u_per.lvl(1'b1);
      wr(ADR_DOUT, 32'hC3C3_0055);
      wait_ack(1'b1, n);
      chk(o_dout_oe, 1'b1);
      chk(o_dout, 32'hC3C3_0055);
      cyc(20);
      chk(o_ack, 1'b1);
      u_per.strobe(32'h0, 32'h0);
      chk(o_ack, 1'b0);
      chk(o_dout, 32'hC3C3_0055);
      chk(o_dout_oe, 1'b1);
      wr(ADR_CTRL, 32'h1073);
      u_per.lvl(1'b1);
      u_per.lvl(1'b0);
      cyc(4);
      chk(o_dout_oe, 1'b0);
   endtask
   task automatic s_edge(input logic [31:0] c, input int w, input logic trail);
      wr(ADR_CTRL, 32'h0);
      apol = c[CB_ACK_POL];
      u_per.act = c[CB_REQ_POL];
      u_per.lvl(1'b0);
      cyc(4);
      wr(ADR_CTRL, c);
      wait_ack(1'b1, n);
      wait_ack(1'b0, n);
      chk(n >= w - 1 && n <= w + 1, 1'b1);
      u_per.strobe(32'h1111_0000 + w, 32'h2222_0000 + w);
      rd(ADR_DIN, trail ? 32'h2222_0000 + w : 32'h1111_0000 + w);
   endtask
   // ***************************************************
   // main sequence and watchdog
   // ***************************************************
   initial begin
      i_rst_n = 1'b0;
      i_addr = 4'h0;
      i_wdata = 32'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      repeat (20) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      cyc(1);
      s_reset();
      s_level_in();
      s_delay();
      s_no_latch();
      s_level_out();
      s_edge(32'h75, 25, 1'b1);
      s_edge(32'h79, 25, 1'b0);
      s_edge(32'h57D, 30, 1'b0);
      s_edge(32'h84D, 50, 1'b0);
      end_of_test();
   end
   // the whole run needs under a thousand cycles; this cuts a hang short
   initial begin
      #200000;
      error_cnt++;
      end_of_test();
   end
endmodule

// >>> verilog/lhp_pkg.sv
// constants, types and register map of the level and edge handshake port
package lhp_pkg;

   // ***************************************************
   // timing
   // ***************************************************
   localparam int CLK_NS       = 10;
   localparam int DLY_STEP_NS  = 100;
   localparam int DLY_MAX_NS   = 700;
   localparam int ACK_PULSE_NS = 250;
   localparam int LONG_MIN_NS  = 500;
   localparam int LONG_BASE_NS = 100;
   localparam int SETTLE_NS    = 100;

   localparam int CNT_W = 8;
   typedef logic [CNT_W-1:0] lhp_cnt_t;

   localparam lhp_cnt_t DLY_STEP_CYC  = CNT_W'((DLY_STEP_NS + CLK_NS - 1) / CLK_NS);
   localparam lhp_cnt_t DLY_MAX_STEPS = CNT_W'(DLY_MAX_NS / DLY_STEP_NS);
   localparam lhp_cnt_t PULSE_CYC     = CNT_W'((ACK_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam lhp_cnt_t LONG_MIN_CYC  = CNT_W'((LONG_MIN_NS + CLK_NS - 1) / CLK_NS);
   localparam lhp_cnt_t LONG_BASE_CYC = CNT_W'((LONG_BASE_NS + CLK_NS - 1) / CLK_NS);
   localparam lhp_cnt_t SETTLE_CYC    = CNT_W'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

   // ***************************************************
   // register map
   // ***************************************************
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] ADR_STAT = 4'h4;
   localparam logic [ADDR_W-1:0] ADR_DOUT = 4'h8;
   localparam logic [ADDR_W-1:0] ADR_DIN  = 4'hC;

   localparam int CB_EN      = 0;
   localparam int CB_DIR     = 1;
   localparam int CB_PROTO   = 2;
   localparam int CB_ACK_POL = 4;
   localparam int CB_REQ_POL = 5;
   localparam int CB_IN_LAT  = 6;
   localparam int CB_DLY     = 7;
   localparam int CB_SETTLE  = 10;
   localparam int CB_MIN500  = 11;
   localparam int CB_OUT_LAT = 12;
   localparam int CTRL_W     = 13;
   localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0070;

   // ***************************************************
   // enumerations
   // ***************************************************
   typedef enum logic [1:0] {
      PR_LEVEL = 2'b00,
      PR_TRAIL = 2'b01,
      PR_LEAD  = 2'b10,
      PR_LONG  = 2'b11
   } lhp_proto_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_ACK   = 3'b010,
      ST_PULSE = 3'b011,
      ST_XFER  = 3'b100
   } lhp_state_t;

endpackage

// >>> verilog/lhp_port.sv
// level and edge handshake port: handshake engine and register slave
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
// Summary of operation
// - idle keeps ack inactive; only level input awaits request, other modes need only readiness
// - input ack only with buffer space
// - ack held until active-going request edge
// - request edge drops ack, captures data if latching on
// - programmable delay before each ack, except long pulse
// - latching on: data valid before edge
// - output drives data before ack
// - already active request must toggle first
// - output latching releases data after deassert
// - trailing edge of pulse means ready
// - leading edge of pulse means ready
// - long pulse: delay widens pulse, settle
// - long pulse minimum width 500 ns
// - delay 0 to 700 ns, 100 ns steps
// - ack and request polarity programmable
module lhp_port
   import lhp_pkg::*;
#(
   parameter int DATA_W = 32
) (
   // clock and reset
   input  wire logic                i_core_clk,
   input  wire logic                i_rst_n,
   // register port
   input  wire logic [ADDR_W-1:0]   i_addr,
   input  wire logic [31:0]         i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic      [31:0]         o_rdata,
   // handshake pins
   input  wire logic                i_req,
   output logic                     o_ack,
   // data pins
   input  wire logic [DATA_W-1:0]   i_din,
   output logic      [DATA_W-1:0]   o_dout,
   output logic                     o_dout_oe
);

   // ***************************************************
   // parameter check
   // ***************************************************
   generate
      if (DATA_W < 1 || DATA_W > 32) begin : g_bad_w
         $error("DATA_W must lie in 1..32");
      end
   endgenerate

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   logic              req_act;
   logic              req_rise;
   logic              req_fall;
   logic [DATA_W-1:0] din_m_q;
   logic [DATA_W-1:0] din_s_q;
   logic [CTRL_W-1:0] ctrl_q, ctrl_d;

   lhp_req_sync u_req_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_req      (i_req),
      .i_pol      (ctrl_q[CB_REQ_POL]),
      .o_act      (req_act),
      .o_rise     (req_rise),
      .o_fall     (req_fall)
   );

   // data bus is sampled every cycle through two register stages
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         din_m_q <= '0;
         din_s_q <= '0;
      end else begin
         din_m_q <= i_din;
         din_s_q <= din_m_q;
      end
   end

   // ***************************************************
   // state
   // ***************************************************
   lhp_state_t        st_q, st_d;
   lhp_cnt_t          cnt_q, cnt_d;
   logic              act_q, act_d;
   logic              armed_q, armed_d;
   logic              pend_q, pend_d;
   logic              in_full_q, in_full_d;
   logic              out_full_q, out_full_d;
   logic [DATA_W-1:0] din_q, din_d;
   logic [DATA_W-1:0] oword_q, oword_d;
   logic [DATA_W-1:0] dout_q, dout_d;
   logic              oe_q, oe_d;
   logic              ack_q, ack_d;
   logic [31:0]       rdata_q, rdata_d;

   lhp_proto_t proto;
   logic       en;
   logic       dir_out;
   lhp_cnt_t   dly_cyc;
   logic       peer_edge;
   logic       ready;
   logic       capture;
   logic       fetch;

   assign proto   = lhp_proto_t'(ctrl_q[CB_PROTO +: 2]);
   assign en      = ctrl_q[CB_EN];
   assign dir_out = ctrl_q[CB_DIR];
   assign dly_cyc = CNT_W'(ctrl_q[CB_DLY +: 3]) * DLY_STEP_CYC;
   // trailing protocol treats the falling edge of the pulse as ready
   assign peer_edge = (proto == PR_TRAIL) ? req_fall : req_rise;
   assign ready     = dir_out ? out_full_q : !in_full_q;

   // ***************************************************
   // next state
   // ***************************************************
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      act_d   = act_q;
      armed_d = armed_q;
      pend_d  = pend_q;
      dout_d  = dout_q;
      oe_d    = oe_q;
      capture = 1'b0;
      fetch   = 1'b0;
      case (st_q)
         ST_IDLE: begin
            act_d = 1'b0;
            if (req_act || req_rise) begin
               armed_d = 1'b1;
            end
            if (ctrl_q[CB_OUT_LAT] && oe_q && !out_full_q && req_fall) begin
               oe_d = 1'b0;
            end
            if (en && ready && (dir_out || proto != PR_LEVEL || armed_q)) begin
               st_d = ST_WAIT;
               if (proto == PR_LONG) begin
                  cnt_d = ctrl_q[CB_SETTLE] ? SETTLE_CYC : '0;
               end else begin
                  cnt_d = dly_cyc;
               end
               if (dir_out) begin
                  dout_d = oword_q;
                  oe_d   = 1'b1;
               end
            end
         end
         ST_WAIT: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else if (proto == PR_LEVEL) begin
               st_d  = ST_ACK;
               act_d = 1'b1;
               if (pend_q) begin
                  capture = 1'b1;
                  pend_d  = 1'b0;
               end
            end else begin
               st_d  = ST_PULSE;
               act_d = 1'b1;
               if (proto == PR_LONG) begin
                  // delay stretches the pulse instead of postponing it
                  cnt_d = (ctrl_q[CB_MIN500] ? LONG_MIN_CYC : LONG_BASE_CYC)
                        + dly_cyc;
               end else begin
                  cnt_d = PULSE_CYC;
               end
            end
         end
         ST_ACK: begin
            // a held request is no edge: the peripheral must toggle
            if (req_rise) begin
               act_d = 1'b0;
               st_d  = ST_IDLE;
               if (dir_out) begin
                  fetch = 1'b1;
               end else if (ctrl_q[CB_IN_LAT]) begin
                  capture = 1'b1;
               end else begin
                  pend_d = 1'b1;
               end
            end
         end
         ST_PULSE: begin
            if (cnt_q > 1) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               act_d = 1'b0;
               st_d  = ST_XFER;
            end
         end
         ST_XFER: begin
            if (peer_edge) begin
               st_d = ST_IDLE;
               if (dir_out) begin
                  fetch = 1'b1;
               end else begin
                  capture = 1'b1;
               end
            end
         end
         default: begin
            st_d  = ST_IDLE;
            act_d = 1'b0;
         end
      endcase
      if (!en) begin
         st_d    = ST_IDLE;
         act_d   = 1'b0;
         armed_d = 1'b0;
         pend_d  = 1'b0;
      end
      ack_d = act_d ? ctrl_d[CB_ACK_POL] : ~ctrl_d[CB_ACK_POL];
   end

   // ***************************************************
   // register slave next values
   // ***************************************************
   always_comb begin
      ctrl_d     = ctrl_q;
      oword_d    = oword_q;
      in_full_d  = in_full_q;
      out_full_d = out_full_q;
      din_d      = din_q;
      rdata_d    = '0;
      if (i_wr && i_addr == ADR_CTRL) begin
         if (st_q == ST_IDLE) begin
            ctrl_d = i_wdata[CTRL_W-1:0];
         end else begin
            ctrl_d[CB_EN] = i_wdata[CB_EN];
         end
      end
      if (i_rd) begin
         case (i_addr)
            ADR_CTRL: rdata_d = 32'(ctrl_q);
            ADR_STAT: rdata_d = 32'({st_q, armed_q, pend_q, oe_q, act_q,
                                     out_full_q, in_full_q});
            ADR_DIN: begin
               rdata_d   = 32'(din_q);
               in_full_d = 1'b0;
            end
            default: rdata_d = '0;
         endcase
      end
      if (fetch) begin
         out_full_d = 1'b0;
      end
      // a new word or a capture in the same cycle wins over the clear
      if (i_wr && i_addr == ADR_DOUT) begin
         oword_d    = i_wdata[DATA_W-1:0];
         out_full_d = 1'b1;
      end
      if (capture) begin
         din_d     = din_s_q;
         in_full_d = 1'b1;
      end
   end

   // ***************************************************
   // registers
   // ***************************************************
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         ctrl_q     <= CTRL_RST;
         st_q       <= ST_IDLE;
         cnt_q      <= '0;
         act_q      <= 1'b0;
         armed_q    <= 1'b0;
         pend_q     <= 1'b0;
         in_full_q  <= 1'b0;
         out_full_q <= 1'b0;
         din_q      <= '0;
         oword_q    <= '0;
         dout_q     <= '0;
         oe_q       <= 1'b0;
         ack_q      <= 1'b0;
         rdata_q    <= '0;
      end else begin
         ctrl_q     <= ctrl_d;
         st_q       <= st_d;
         cnt_q      <= cnt_d;
         act_q      <= act_d;
         armed_q    <= armed_d;
         pend_q     <= pend_d;
         in_full_q  <= in_full_d;
         out_full_q <= out_full_d;
         din_q      <= din_d;
         oword_q    <= oword_d;
         dout_q     <= dout_d;
         oe_q       <= oe_d;
         ack_q      <= ack_d;
         rdata_q    <= rdata_d;
      end
   end

   assign o_ack     = ack_q;
   assign o_dout    = dout_q;
   assign o_dout_oe = oe_q;
   assign o_rdata   = rdata_q;

   // ***************************************************
   // checks
   // ***************************************************
   lhp_cnt_t hi_cnt_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         hi_cnt_q <= '0;
      end else if (act_q) begin
         hi_cnt_q <= hi_cnt_q + 1'b1;
      end else begin
         hi_cnt_q <= '0;
      end
   end

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   idle_ack_off_a: assert property (
      (st_q == ST_IDLE) |-> (!act_q && ack_q == ~ctrl_q[CB_ACK_POL]))
      else $error("ack active while idle");

   ack_hold_a: assert property (
      (st_q == ST_ACK && en && !req_rise) |=> (act_q && st_q == ST_ACK))
      else $error("ack dropped without request edge");

   ack_drop_a: assert property (
      (st_q == ST_ACK && en && req_rise) |=> (!act_q ##1 !act_q))
      else $error("ack not dropped on request edge");

   edge_capture_a: assert property (
      (st_q == ST_ACK && en && req_rise && !dir_out && ctrl_q[CB_IN_LAT])
      |=> (in_full_q && din_q == $past(din_s_q)))
      else $error("input word not captured on request edge");

   space_first_a: assert property (
      ($rose(act_q) && !dir_out) |-> !$past(in_full_q))
      else $error("ack raised with full buffer");

   data_first_a: assert property (
      ($rose(act_q) && dir_out) |-> (oe_q && $past(oe_q) && dout_q == $past(dout_q)))
      else $error("ack raised before output data");

   delay_src_a: assert property (
      $rose(act_q) |-> ($past(st_q) == ST_WAIT && $past(cnt_q) == '0))
      else $error("ack raised without delay phase");

   pulse_len_a: assert property (
      ($fell(act_q) && (proto == PR_TRAIL || proto == PR_LEAD) && st_q == ST_XFER)
      |-> ($past(hi_cnt_q) == PULSE_CYC - 1'b1))
      else $error("edge pulse width wrong");

   proto_lock_a: assert property (
      (st_q != ST_IDLE) |=> $stable(ctrl_q[CB_PROTO +: 2]))
      else $error("protocol changed while busy");

   long_min_a: assert property (
      ($fell(act_q) && proto == PR_LONG && ctrl_q[CB_MIN500] && st_q == ST_XFER)
      |-> ($past(hi_cnt_q) >= LONG_MIN_CYC - 1'b1))
      else $error("long pulse shorter than minimum");

endmodule

// >>> verilog/lhp_req_sync.sv
// request pin synchroniser with polarity and edge pulses
`timescale 1ns/1ns
module lhp_req_sync (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // pin and polarity
   input  wire logic i_req,
   input  wire logic i_pol,
   // active-level view
   output logic      o_act,
   output logic      o_rise,
   output logic      o_fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic act;

   // first stage feeds only the second
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= i_req;
         sync_q <= meta_q;
         prev_q <= act;
      end
   end

   assign act    = i_pol ? sync_q : ~sync_q;
   assign o_act  = act;
   assign o_rise = act & ~prev_q;
   assign o_fall = ~act & prev_q;
endmodule
